// file: verilog/pfs_defines.svh
// Purpose: constants for the pin function select block
// Assumes: 4-bit alternate-function fields, 16-bit config registers
// Notes: field codes are plain defaults
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_CFG_W 16
`define PFS_FLD_W 4
`define PFS_A6_FLD_LSB 8
`define PFS_TD3_FLD_LSB 4
`define PFS_B1_FLD_LSB 4
`define PFS_B2_FLD_LSB 8
`define PFS_C2_FLD_LSB 8
`define PFS_MODE_W 2
`define PFS_MODE_OFF 2'h0
`define PFS_MODE_UART 2'h1
`define PFS_MODE_SPI 2'h2
`define PFS_MODE_TWI 2'h3
`define PFS_CODE_ALT_OUT 4'h9
`define PFS_CODE_ALT_OD 4'hd
`define PFS_REMAP_C1_BIT 4
`define PFS_REMAP_C2_BIT 5
`define PFS_DBG_GPIO_BIT 5
`define PFS_SYNC_STAGES 3
`endif

// file: verilog/pfs_pkg.sv
// Purpose: types for the pin function select block
// Assumes: pfs_defines.svh constants
// Notes: none
`include "pfs_defines.svh"
package pfs_pkg;
    typedef logic [`PFS_MODE_W-1:0] pfs_mode_t;
    typedef logic [`PFS_CFG_W-1:0] pfs_cfg_t;
    typedef enum logic [0:0] {
        PFS_DBG_JTAG = 1'b0,
        PFS_DBG_SWD = 1'b1
    } pfs_dbg_t;
endpackage

// file: verilog/pfs_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: asynchronous source
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pfs_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic [2:0] stg;
        logic q;
    } pfs_sync_st_t;
    pfs_sync_st_t st_reg;
    pfs_sync_st_t st_next;
    always_comb begin
        st_next = st_reg;
        st_next.stg = {st_reg.stg[1:0], d};
        // First stage feeds only the second
        if (st_reg.stg[1] == st_reg.stg[2]) begin
            st_next.q = st_reg.stg[2];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= {{3{RESET_VAL}}, RESET_VAL};
        end else begin
            st_reg <= st_next;
        end
    end
    assign q = st_reg.q;
endmodule
`default_nettype wire

// file: verilog/pfs_field.sv
// Purpose: decode of one alternate-function config field
// Assumes: 4-bit field
// Notes: registered flags, one cycle behind the config
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.svh"
module pfs_field #(
    parameter int LSB = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire pfs_pkg::pfs_cfg_t cfg,
    output logic alt_out,
    output logic alt_od
);
    import pfs_pkg::*;
    typedef struct packed {
        logic out;
        logic od;
    } pfs_fld_st_t;
    pfs_fld_st_t st_reg;
    pfs_fld_st_t st_next;
    logic [`PFS_FLD_W-1:0] fld;
    always_comb begin
        fld = cfg[LSB +: `PFS_FLD_W];
        st_next.out = (fld == `PFS_CODE_ALT_OUT);
        st_next.od = (fld == `PFS_CODE_ALT_OD);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign alt_out = st_reg.out;
    assign alt_od = st_reg.od;
endmodule
`default_nettype wire

// file: verilog/pfs_pin_select.sv
//
// Functional notes
// - Port A six drives timer one ch3
// - Timer one ch3 input always port A six
// - SPI: port B one outputs slave/master data
// - Two-wire: port B one open-drain data
// - UART: port B one transmits data
// - Timer two, when it claims B one, wins over serial1
// - Remapped timer two ch1 on B one
// - Timer two ch1 input from B one unremapped
// - SPI master: B two gives data in
// - SPI slave: B two gives data in
// - Two-wire: B two open-drain clock
// - UART: B two gives receive data
// - Remapped timer two ch2 on B two
// - Remapped timer two ch2 input from B two
// - Debug clock: serial-wire or test clock
// - C two GPIO or test output
// - C two async trace in serial-wire
// - C three GPIO or test data input
// - Trace bit three on alternate field
// - JTAG default after reset, debugger switches
//
// Purpose: pin function selection for A6, B1, B2 and debug pins
// Assumes: pad inputs are asynchronous; peripheral signals share clk
// Notes: pad outputs are registered, so routing lags the alternate-function fields by two cycles and other config by one
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.svh"
module pfs_pin_select (
    input wire logic clk,
    input wire logic rst,
    input wire pfs_pkg::pfs_cfg_t port_a_high_config,
    input wire pfs_pkg::pfs_cfg_t port_b_low_config,
    input wire pfs_pkg::pfs_cfg_t port_c_low_config,
    input wire pfs_pkg::pfs_cfg_t debug_pin_config,
    input wire pfs_pkg::pfs_cfg_t timer_two_remap_reg,
    input wire pfs_pkg::pfs_mode_t serial1_mode_select,
    input wire logic serial1_spi_role_config,
    input wire logic timer_one_ch3_out_en,
    input wire logic timer_two_ch1_out_en,
    input wire logic timer_two_ch2_out_en,
    input wire logic trace_enable,
    input wire logic trace_async_sel,
    input wire logic trace_sync4_sel,
    input wire logic swd_mode_request,
    input wire logic timer_one_channel_three_out,
    input wire logic timer_two_channel_one_out,
    input wire logic timer_two_channel_two_out,
    input wire logic serial1_master_in_slave_out_out,
    input wire logic serial1_master_out_slave_in_out,
    input wire logic serial1_uart_transmit_out,
    input wire logic serial1_twowire_data_out,
    input wire logic serial1_twowire_clock_out,
    input wire logic test_data_output_out,
    input wire logic test_data_output_en,
    input wire logic swd_clock_out,
    input wire logic swd_clock_oe,
    input wire logic async_trace_output_out,
    input wire logic sync_trace_bit_three_out,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    input wire logic port_a_pin_six_in,
    input wire logic port_b_pin_one_in,
    input wire logic port_b_pin_two_in,
    input wire logic debug_clock_pin_in,
    input wire logic port_c_pin_three_in,
    output logic port_a_pin_six_out,
    output logic port_a_pin_six_oe,
    output logic port_b_pin_one_out,
    output logic port_b_pin_one_oe,
    output logic port_b_pin_two_out,
    output logic port_b_pin_two_oe,
    output logic debug_clock_pin_out,
    output logic debug_clock_pin_oe,
    output logic debug_clock_pulldown,
    output logic port_c_pin_two_out,
    output logic port_c_pin_two_oe,
    output logic port_c_pin_two_pullup,
    output logic port_c_pin_three_pullup,
    output logic sync_trace_pin_out,
    output logic sync_trace_pin_oe,
    output logic timer_one_channel_three_in,
    output logic timer_two_channel_one_in,
    output logic timer_two_channel_two_in,
    output logic serial1_master_in_slave_out_in,
    output logic serial1_master_out_slave_in_in,
    output logic serial1_uart_receive_in,
    output logic serial1_twowire_data_in,
    output logic serial1_twowire_clock_in,
    output logic test_clock_input,
    output logic test_data_input,
    output logic debug_mode_swd
);
    import pfs_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic a6_s;
    logic b1_s;
    logic b2_s;
    logic dclk_s;
    logic c3_s;
    pfs_sync #(.RESET_VAL(1'b0)) u_sync_a6 (.clk(clk), .rst(rst), .d(port_a_pin_six_in), .q(a6_s));
    pfs_sync #(.RESET_VAL(1'b1)) u_sync_b1 (.clk(clk), .rst(rst), .d(port_b_pin_one_in), .q(b1_s));
    pfs_sync #(.RESET_VAL(1'b1)) u_sync_b2 (.clk(clk), .rst(rst), .d(port_b_pin_two_in), .q(b2_s));
    pfs_sync #(.RESET_VAL(1'b0)) u_sync_dc (.clk(clk), .rst(rst), .d(debug_clock_pin_in), .q(dclk_s));
    pfs_sync #(.RESET_VAL(1'b1)) u_sync_c3 (.clk(clk), .rst(rst), .d(port_c_pin_three_in), .q(c3_s));

    // ----------------------------------------
    // Alternate-function field decode
    // ----------------------------------------
    logic a6_alt;
    logic td3_alt;
    logic b1_alt;
    logic b1_od;
    logic b2_alt;
    logic b2_od;
    logic c2_alt;
    pfs_field #(.LSB(`PFS_A6_FLD_LSB)) u_fld_a6 (.clk(clk), .rst(rst), .cfg(port_a_high_config),
        .alt_out(a6_alt), .alt_od());
    pfs_field #(.LSB(`PFS_TD3_FLD_LSB)) u_fld_td3 (.clk(clk), .rst(rst), .cfg(port_a_high_config),
        .alt_out(td3_alt), .alt_od());
    pfs_field #(.LSB(`PFS_B1_FLD_LSB)) u_fld_b1 (.clk(clk), .rst(rst), .cfg(port_b_low_config),
        .alt_out(b1_alt), .alt_od(b1_od));
    pfs_field #(.LSB(`PFS_B2_FLD_LSB)) u_fld_b2 (.clk(clk), .rst(rst), .cfg(port_b_low_config),
        .alt_out(b2_alt), .alt_od(b2_od));
    pfs_field #(.LSB(`PFS_C2_FLD_LSB)) u_fld_c2 (.clk(clk), .rst(rst), .cfg(port_c_low_config),
        .alt_out(c2_alt), .alt_od());

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        pfs_dbg_t dbg;
        logic a6_o;
        logic a6_e;
        logic b1_o;
        logic b1_e;
        logic b2_o;
        logic b2_e;
        logic dc_o;
        logic dc_e;
        logic dc_pd;
        logic c2_o;
        logic c2_e;
        logic c2_pu;
        logic c3_pu;
        logic td_o;
        logic td_e;
        logic t1c3_i;
        logic t2c1_i;
        logic t2c2_i;
        logic miso_i;
        logic mosi_i;
        logic rxd_i;
        logic sda_i;
        logic scl_i;
        logic tck_i;
        logic tdi_i;
    } pfs_st_t;
    pfs_st_t st_reg;
    pfs_st_t st_next;

    // Open-drain drive: enable only when pulling low
    function automatic logic od_en(input logic v);
        od_en = ~v;
    endfunction

    logic spi;
    logic twi;
    logic uart;
    logic slave;
    logic t2c1_remap;
    logic t2c2_remap;
    logic b1_timer_owns;
    logic b2_timer_owns;
    logic dbg_gpio;
    logic swd;

    always_comb begin
        spi = (serial1_mode_select == `PFS_MODE_SPI);
        twi = (serial1_mode_select == `PFS_MODE_TWI);
        uart = (serial1_mode_select == `PFS_MODE_UART);
        slave = serial1_spi_role_config;
        t2c1_remap = timer_two_remap_reg[`PFS_REMAP_C1_BIT];
        t2c2_remap = timer_two_remap_reg[`PFS_REMAP_C2_BIT];
        b1_timer_owns = timer_two_ch1_out_en & t2c1_remap;
        b2_timer_owns = timer_two_ch2_out_en & t2c2_remap;
        dbg_gpio = debug_pin_config[`PFS_DBG_GPIO_BIT];
        swd = (st_reg.dbg == PFS_DBG_SWD);

        st_next = st_reg;
        // Serial-wire switch is made by the debug port; reset returns to JTAG
        st_next.dbg = swd_mode_request ? PFS_DBG_SWD : PFS_DBG_JTAG;

        // Port A six
        st_next.a6_o = gpio_out[0];
        st_next.a6_e = gpio_oe[0];
        if (timer_one_ch3_out_en && a6_alt) begin
            st_next.a6_o = timer_one_channel_three_out;
            st_next.a6_e = 1'b1;
        end
        st_next.t1c3_i = a6_s;

        // Port B one
        st_next.b1_o = gpio_out[1];
        st_next.b1_e = gpio_oe[1];
        if (b1_timer_owns && b1_alt) begin
            st_next.b1_o = timer_two_channel_one_out;
            st_next.b1_e = 1'b1;
        end else if (!b1_timer_owns && spi && b1_alt) begin
            st_next.b1_o = slave ? serial1_master_in_slave_out_out
                                 : serial1_master_out_slave_in_out;
            st_next.b1_e = 1'b1;
        end else if (!b1_timer_owns && twi && b1_od) begin
            st_next.b1_o = 1'b0;
            st_next.b1_e = od_en(serial1_twowire_data_out);
        end else if (!b1_timer_owns && uart && b1_alt) begin
            st_next.b1_o = serial1_uart_transmit_out;
            st_next.b1_e = 1'b1;
        end
        st_next.t2c1_i = t2c1_remap ? 1'b0 : b1_s;
        st_next.sda_i = b1_s;

        // Port B two
        st_next.b2_o = gpio_out[2];
        st_next.b2_e = gpio_oe[2];
        if (b2_timer_owns && b2_alt) begin
            st_next.b2_o = timer_two_channel_two_out;
            st_next.b2_e = 1'b1;
        end else if (!b2_timer_owns && twi && b2_od) begin
            st_next.b2_o = 1'b0;
            st_next.b2_e = od_en(serial1_twowire_clock_out);
        end
        st_next.miso_i = (spi && !slave) ? b2_s : 1'b1;
        st_next.mosi_i = (spi && slave) ? b2_s : 1'b1;
        st_next.rxd_i = uart ? b2_s : 1'b1;
        st_next.scl_i = b2_s;
        st_next.t2c2_i = t2c2_remap ? b2_s : 1'b0;

        // Debug clock pin
        st_next.dc_pd = !swd;
        st_next.dc_o = swd ? swd_clock_out : 1'b0;
        st_next.dc_e = swd & swd_clock_oe;
        st_next.tck_i = swd ? 1'b0 : dclk_s;

        // Port C two
        st_next.c2_o = gpio_out[3];
        st_next.c2_e = gpio_oe[3];
        st_next.c2_pu = 1'b0;
        if (!dbg_gpio) begin
            if (swd && trace_enable && trace_async_sel && c2_alt) begin
                st_next.c2_o = async_trace_output_out;
                st_next.c2_e = 1'b1;
                st_next.c2_pu = 1'b1;
            end else if (!swd) begin
                st_next.c2_o = test_data_output_out;
                st_next.c2_e = test_data_output_en;
            end
        end

        // Port C three
        st_next.c3_pu = !(dbg_gpio || swd);
        st_next.tdi_i = (dbg_gpio || swd) ? 1'b1 : c3_s;

        // Trace data bit three
        st_next.td_o = sync_trace_bit_three_out;
        st_next.td_e = trace_enable && trace_sync4_sel && td3_alt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.dc_pd <= 1'b1;
            st_reg.c3_pu <= 1'b1;
            st_reg.miso_i <= 1'b1;
            st_reg.mosi_i <= 1'b1;
            st_reg.rxd_i <= 1'b1;
            st_reg.sda_i <= 1'b1;
            st_reg.scl_i <= 1'b1;
            st_reg.tdi_i <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign port_a_pin_six_out = st_reg.a6_o;
    assign port_a_pin_six_oe = st_reg.a6_e;
    assign port_b_pin_one_out = st_reg.b1_o;
    assign port_b_pin_one_oe = st_reg.b1_e;
    assign port_b_pin_two_out = st_reg.b2_o;
    assign port_b_pin_two_oe = st_reg.b2_e;
    assign debug_clock_pin_out = st_reg.dc_o;
    assign debug_clock_pin_oe = st_reg.dc_e;
    assign debug_clock_pulldown = st_reg.dc_pd;
    assign port_c_pin_two_out = st_reg.c2_o;
    assign port_c_pin_two_oe = st_reg.c2_e;
    assign port_c_pin_two_pullup = st_reg.c2_pu;
    assign port_c_pin_three_pullup = st_reg.c3_pu;
    assign sync_trace_pin_out = st_reg.td_o;
    assign sync_trace_pin_oe = st_reg.td_e;
    assign timer_one_channel_three_in = st_reg.t1c3_i;
    assign timer_two_channel_one_in = st_reg.t2c1_i;
    assign timer_two_channel_two_in = st_reg.t2c2_i;
    assign serial1_master_in_slave_out_in = st_reg.miso_i;
    assign serial1_master_out_slave_in_in = st_reg.mosi_i;
    assign serial1_uart_receive_in = st_reg.rxd_i;
    assign serial1_twowire_data_in = st_reg.sda_i;
    assign serial1_twowire_clock_in = st_reg.scl_i;
    assign test_clock_input = st_reg.tck_i;
    assign test_data_input = st_reg.tdi_i;
    assign debug_mode_swd = st_reg.dbg;
endmodule
`default_nettype wire

// file: sim/pfs_pin_select_monitor.sv
// Purpose: port-level assertions for the pin function select block
// Assumes: config reaches pads in up to two edges, pads reach peripherals in up to five
// Notes: causes are held steady over a window, so latency slack never fires
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.svh"
module pfs_pin_select_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire pfs_pkg::pfs_cfg_t port_a_high_config,
    input wire pfs_pkg::pfs_cfg_t port_b_low_config,
    input wire pfs_pkg::pfs_cfg_t debug_pin_config,
    input wire pfs_pkg::pfs_cfg_t timer_two_remap_reg,
    input wire pfs_pkg::pfs_mode_t serial1_mode_select,
    input wire logic serial1_spi_role_config,
    input wire logic timer_one_ch3_out_en,
    input wire logic timer_two_ch1_out_en,
    input wire logic timer_one_channel_three_out,
    input wire logic serial1_master_in_slave_out_out,
    input wire logic serial1_master_out_slave_in_out,
    input wire logic serial1_twowire_data_out,
    input wire logic test_data_output_out,
    input wire logic test_data_output_en,
    input wire logic swd_mode_request,
    input wire logic port_a_pin_six_in,
    input wire logic debug_clock_pin_in,
    input wire logic port_a_pin_six_out,
    input wire logic port_a_pin_six_oe,
    input wire logic port_b_pin_one_out,
    input wire logic port_b_pin_one_oe,
    input wire logic debug_clock_pulldown,
    input wire logic port_c_pin_two_out,
    input wire logic port_c_pin_two_oe,
    input wire logic port_c_pin_three_pullup,
    input wire logic timer_one_channel_three_in,
    input wire logic test_clock_input,
    input wire logic debug_mode_swd
);
    import pfs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Timer two claims B1 only with both enable and remap set
    wire logic b1_free = !(timer_two_ch1_out_en && timer_two_remap_reg[`PFS_REMAP_C1_BIT]);
    wire logic [3:0] b1_fld = port_b_low_config[7:4];
    property p_pa6;
        (port_a_high_config[11:8] == `PFS_CODE_ALT_OUT && timer_one_ch3_out_en
            && $stable(timer_one_channel_three_out)) [*3]
            |-> port_a_pin_six_oe && port_a_pin_six_out == timer_one_channel_three_out;
    endproperty
    a_pa6: assert property (p_pa6) else $error("A6 lost timer output");
    property p_t1in;
        $stable(port_a_pin_six_in) [*8] |-> timer_one_channel_three_in == port_a_pin_six_in;
    endproperty
    a_t1in: assert property (p_t1in) else $error("timer input not from A6");
    property p_b1_spi;
        (serial1_mode_select == `PFS_MODE_SPI && b1_fld == `PFS_CODE_ALT_OUT && b1_free && $stable({
            serial1_spi_role_config, serial1_master_in_slave_out_out, serial1_master_out_slave_in_out})) [*3]
            |-> port_b_pin_one_oe && port_b_pin_one_out == (serial1_spi_role_config ?
            serial1_master_in_slave_out_out : serial1_master_out_slave_in_out);
    endproperty
    a_b1_spi: assert property (p_b1_spi) else $error("B1 SPI data wrong");
    property p_b1_twi;
        (serial1_mode_select == `PFS_MODE_TWI && b1_fld == `PFS_CODE_ALT_OD && b1_free
            && $stable(serial1_twowire_data_out)) [*3]
            |-> !port_b_pin_one_out && port_b_pin_one_oe == !serial1_twowire_data_out;
    endproperty
    a_b1_twi: assert property (p_b1_twi) else $error("B1 open-drain wrong");
    property p_tck;
        (!swd_mode_request && $stable(debug_clock_pin_in)) [*8]
            |-> debug_clock_pulldown && test_clock_input == debug_clock_pin_in;
    endproperty
    a_tck: assert property (p_tck) else $error("test clock path wrong");
    property p_tdo;
        (!swd_mode_request && !debug_pin_config[`PFS_DBG_GPIO_BIT] && test_data_output_en
            && $stable(test_data_output_out)) [*3]
            |-> port_c_pin_two_oe && port_c_pin_two_out == test_data_output_out;
    endproperty
    a_tdo: assert property (p_tdo) else $error("C2 test output wrong");
    property p_mode;
        $stable(swd_mode_request) [*2] |-> debug_mode_swd == swd_mode_request;
    endproperty
    a_mode: assert property (p_mode) else $error("debug mode wrong");
    property p_pc3;
        (!swd_mode_request && !debug_pin_config[`PFS_DBG_GPIO_BIT]) [*3] |-> port_c_pin_three_pullup;
    endproperty
    a_pc3: assert property (p_pc3) else $error("C3 pull-up missing");
endmodule
bind pfs_pin_select pfs_pin_select_monitor mon_u (.*);
`default_nettype wire

// file: sim/pfs_pad_model.sv
// Purpose: far side of the pins: package lines and the debugger
// Assumes: the bench says who drives from outside
// Notes: an undriven A6 or debug clock line with no pull shows the inverse of the pad output; C3 shows the inverse of ext_level[3]
`timescale 1ns/10ps
`default_nettype none
module pfs_pad_model (
    input wire logic port_a_pin_six_out,
    input wire logic port_a_pin_six_oe,
    input wire logic port_b_pin_one_out,
    input wire logic port_b_pin_one_oe,
    input wire logic port_b_pin_two_out,
    input wire logic port_b_pin_two_oe,
    input wire logic debug_clock_pin_out,
    input wire logic debug_clock_pin_oe,
    input wire logic debug_clock_pulldown,
    input wire logic port_c_pin_three_pullup,
    input wire logic [3:0] ext_drive,
    input wire logic [3:0] ext_level,
    output logic port_a_pin_six_in,
    output logic port_b_pin_one_in,
    output logic port_b_pin_two_in,
    output logic debug_clock_pin_in,
    output logic port_c_pin_three_in
);
    assign port_a_pin_six_in = port_a_pin_six_oe ? port_a_pin_six_out : !port_a_pin_six_out;
    // Two-wire lines sit on bus pull-ups when released
    assign port_b_pin_one_in = port_b_pin_one_oe ? port_b_pin_one_out : ext_drive[0] ? ext_level[0] : 1'h1;
    assign port_b_pin_two_in = port_b_pin_two_oe ? port_b_pin_two_out : ext_drive[1] ? ext_level[1] : 1'h1;
    assign debug_clock_pin_in = debug_clock_pin_oe ? debug_clock_pin_out : ext_drive[2] ? ext_level[2]
        : debug_clock_pulldown ? 1'h0 : !debug_clock_pin_out;
    assign port_c_pin_three_in = ext_drive[3] ? ext_level[3] : port_c_pin_three_pullup ? 1'h1 : !ext_level[3];
endmodule
`default_nettype wire

// file: sim/pfs_pin_select_test.sv
// Purpose: self-checking bench for the pin function select block
// Assumes: config up to two edges to pads, pads up to five edges inward
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.svh"
module pfs_pin_select_test;
    import pfs_pkg::*;
    pfs_cfg_t port_a_high_config = '0, port_b_low_config = '0, port_c_low_config = '0;
    pfs_cfg_t debug_pin_config = '0, timer_two_remap_reg = '0;
    pfs_mode_t serial1_mode_select = '0;
    logic clk = '0, rst = 1'h1, serial1_spi_role_config = '0, timer_one_ch3_out_en = '0, timer_two_ch1_out_en = '0;
    logic timer_two_ch2_out_en = '0, trace_enable = '0, trace_async_sel = '0, trace_sync4_sel = '0;
    logic swd_mode_request = '0, timer_one_channel_three_out = '0, timer_two_channel_one_out = '0;
    logic timer_two_channel_two_out = '0, serial1_master_in_slave_out_out = 1'h1, serial1_master_out_slave_in_out = '0;
    logic serial1_uart_transmit_out = 1'h1, serial1_twowire_data_out = '0, serial1_twowire_clock_out = '0;
    logic test_data_output_out = 1'h1, test_data_output_en = 1'h1, swd_clock_out = 1'h1, swd_clock_oe = '0;
    logic async_trace_output_out = 1'h1, sync_trace_bit_three_out = 1'h1;
    logic [3:0] gpio_out = 4'h2, gpio_oe = 4'h3, ext_drive = 4'hc, ext_level = 4'h4;
    logic port_a_pin_six_in, port_b_pin_one_in, port_b_pin_two_in, debug_clock_pin_in, port_c_pin_three_in;
    logic port_a_pin_six_out, port_a_pin_six_oe, port_b_pin_one_out, port_b_pin_one_oe, port_b_pin_two_out;
    logic port_b_pin_two_oe, debug_clock_pin_out, debug_clock_pin_oe, debug_clock_pulldown, port_c_pin_two_out;
    logic port_c_pin_two_oe, port_c_pin_two_pullup, port_c_pin_three_pullup, sync_trace_pin_out, sync_trace_pin_oe;
    logic timer_one_channel_three_in, timer_two_channel_one_in, timer_two_channel_two_in, serial1_uart_receive_in;
    logic serial1_master_in_slave_out_in, serial1_master_out_slave_in_in, serial1_twowire_data_in;
    logic serial1_twowire_clock_in, test_clock_input, test_data_input, debug_mode_swd;
    int checks = 0, failures = 0;
    pfs_pin_select dut_u (.*);
    pfs_pad_model pad_u (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input string n, input logic s, input logic e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic pin1(input pfs_mode_t m, input logic r, input logic [3:0] f, input logic eo);
        serial1_mode_select = m;
        serial1_spi_role_config = r;
        port_b_low_config[7:4] = f;
        wt(4);
        chk("b1_out", port_b_pin_one_out, eo);
        chk("b1_oe", port_b_pin_one_oe, 1'h1);
    endtask
    task automatic t_a6;
        port_a_high_config = 16'h0990;
        timer_one_ch3_out_en = 1'h1;
        timer_one_channel_three_out = 1'h1;
        trace_enable = 1'h1;
        trace_sync4_sel = 1'h1;
        wt(8);
        chk("a6_out", port_a_pin_six_out, 1'h1);
        chk("t1c3_in", timer_one_channel_three_in, 1'h1);
        chk("trace3_oe", sync_trace_pin_oe, 1'h1);
        chk("trace3_out", sync_trace_pin_out, 1'h1);
        timer_one_ch3_out_en = '0;
        trace_sync4_sel = '0;
        wt(3);
        chk("a6_gpio", port_a_pin_six_out, gpio_out[0]);
        chk("trace3_off", sync_trace_pin_oe, 1'h0);
        trace_enable = '0;
        $display("a6 done");
    endtask
    task automatic t_b1;
        pin1(`PFS_MODE_SPI, 1'h1, `PFS_CODE_ALT_OUT, 1'h1);
        pin1(`PFS_MODE_SPI, 1'h0, `PFS_CODE_ALT_OUT, 1'h0);
        pin1(`PFS_MODE_TWI, 1'h0, `PFS_CODE_ALT_OD, 1'h0);
        timer_two_ch1_out_en = 1'h1;
        pin1(`PFS_MODE_UART, 1'h0, `PFS_CODE_ALT_OUT, 1'h1);
        wt(5);
        chk("t2c1_in", timer_two_channel_one_in, 1'h1);
        timer_two_remap_reg = 16'h0010;
        pin1(`PFS_MODE_UART, 1'h0, `PFS_CODE_ALT_OUT, 1'h0);
        timer_two_ch1_out_en = '0;
        pin1(`PFS_MODE_UART, 1'h0, `PFS_CODE_ALT_OUT, 1'h1);
        timer_two_remap_reg = '0;
        port_b_low_config = '0;
        $display("b1 done");
    endtask
    task automatic t_b2;
        ext_drive[1] = 1'h1;
        ext_level[1] = '0;
        gpio_out[1] = '0;
        serial1_mode_select = `PFS_MODE_SPI;
        wt(8);
        chk("miso_in", serial1_master_in_slave_out_in, 1'h0);
        chk("sda_in", serial1_twowire_data_in, 1'h0);
        chk("scl_in", serial1_twowire_clock_in, 1'h0);
        serial1_spi_role_config = 1'h1;
        wt(8);
        chk("mosi_in", serial1_master_out_slave_in_in, 1'h0);
        serial1_mode_select = `PFS_MODE_UART;
        wt(8);
        chk("rx_in", serial1_uart_receive_in, 1'h0);
        ext_drive[1] = '0;
        serial1_mode_select = `PFS_MODE_TWI;
        port_b_low_config[11:8] = `PFS_CODE_ALT_OD;
        wt(3);
        chk("scl_oe", port_b_pin_two_oe, 1'h1);
        timer_two_remap_reg = 16'h0020;
        timer_two_ch2_out_en = 1'h1;
        timer_two_channel_two_out = 1'h1;
        wt(3);
        chk("scl_refused", port_b_pin_two_oe, 1'h0);
        port_b_low_config[11:8] = `PFS_CODE_ALT_OUT;
        wt(8);
        chk("t2c2_out", port_b_pin_two_out, 1'h1);
        chk("t2c2_in", timer_two_channel_two_in, 1'h1);
        gpio_out[1] = 1'h1;
        $display("b2 done");
    endtask
    task automatic t_dbg;
        chk("tck_in", test_clock_input, 1'h1);
        chk("tdi_in", test_data_input, 1'h0);
        chk("tdo_out", port_c_pin_two_out, 1'h1);
        test_data_output_out = '0;
        swd_mode_request = 1'h1;
        swd_clock_oe = 1'h1;
        trace_enable = 1'h1;
        trace_async_sel = 1'h1;
        port_c_low_config = 16'h0900;
        wt(3);
        chk("mode_swd", debug_mode_swd, 1'h1);
        chk("swclk_oe", debug_clock_pin_oe, 1'h1);
        chk("swclk_out", debug_clock_pin_out, 1'h1);
        chk("swo_out", port_c_pin_two_out, 1'h1);
        chk("swo_pullup", port_c_pin_two_pullup, 1'h1);
        chk("c3_pullup", port_c_pin_three_pullup, 1'h0);
        debug_pin_config = 16'h0020;
        wt(3);
        chk("c2_gpio", port_c_pin_two_oe, gpio_oe[3]);
        $display("dbg done");
    endtask
    task automatic t_rst;
        wt(8);
        chk("mode_jtag", debug_mode_swd, 1'h0);
        chk("tck_pulldown", debug_clock_pulldown, 1'h1);
        chk("b1_gpio", port_b_pin_one_out, gpio_out[1]);
        $display("rst done");
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #2;
        rst = '0;
        t_rst;
        t_a6;
        t_b1;
        t_b2;
        t_dbg;
        results;
    end
    initial begin
        #1ms;
        failures++;
        results;
    end
endmodule
`default_nettype wire
